// ==== hw/serdes_tx_pkg.sv ====
// constants, types and decoders shared by the serdes transmit setting logic
package serdes_tx_pkg;
   localparam int NQ     = 2;
   localparam int NL     = 4;
   localparam int NLT    = NQ * NL;
   localparam int LSB_W  = 2;
   localparam int NSRC   = 3;
   localparam int SB     = 2;
   localparam int AW     = 8;
   localparam int DW     = 34;
   localparam int TM_W   = 3;
   localparam int DVL_W  = 5;
   localparam int DC_W   = 3;
   localparam int EQ_W   = 2;
   localparam int SLEW_W = 2;
   localparam int RXEQ_W = 4;

   // write sources, lowest index wins
   localparam int SRC_CFG = 0;
   localparam int SRC_SMB = 1;
   localparam int SRC_EE  = 2;

   // register addresses, quad or lane index in the low bits
   localparam logic [AW-1:0] A_FIRST  = 8'h00;
   localparam logic [AW-1:0] A_SECOND = 8'h04;
   localparam logic [AW-1:0] A_APPLY  = 8'h08;
   localparam logic [AW-1:0] A_RXEQ   = 8'h10;

   // lane_tx_ctrl_first fields
   localparam int F_CSLEW1  = 0;
   localparam int F_CSLEW2  = 2;
   localparam int F_FSLEW1  = 4;
   localparam int F_FSLEW2  = 6;
   localparam int F_EQ35R1  = 8;
   localparam int F_EQ35R2  = 10;
   localparam int F_EQ60R2  = 12;
   localparam int F_CDC35R1 = 14;
   localparam int F_CDC35R2 = 17;
   localparam int F_CDC60R2 = 20;
   localparam int FIRST_W   = 23;
   // lane_tx_ctrl_second fields
   localparam int F_FDC35R1 = 0;
   localparam int F_FDC35R2 = 3;
   localparam int F_FDC60R2 = 6;
   localparam int F_DVL35R1 = 9;
   localparam int F_DVL35R2 = 14;
   localparam int F_DVL60R2 = 19;
   localparam int F_DVLLSR1 = 24;
   localparam int F_DVLLSR2 = 29;
   localparam int SECOND_W  = 34;
   // quad_lane_apply_ctrl fields
   localparam int F_LANE  = 0;
   localparam int F_ALL   = 2;
   localparam int APPLY_W = 3;

   localparam logic [FIRST_W-1:0] FIRST_RST =
      {3'h2, 3'h1, 3'h3, 2'h1, 2'h1, 2'h2, 2'h1, 2'h1, 2'h0, 2'h2};
   localparam logic [SECOND_W-1:0] SECOND_RST =
      {5'h0E, 5'h0E, 5'h1C, 5'h1C, 5'h1C, 3'h4, 3'h3, 3'h3};
   localparam logic [APPLY_W-1:0] APPLY_RST = 3'h4;
   localparam logic [RXEQ_W-1:0]  RXEQ_RST  = 4'h0;
   localparam logic [TM_W-1:0]    TM_NORMAL = 3'h0;

   typedef enum logic [2:0] {
      MODE_FS35_R1 = 3'b000,
      MODE_FS35_R2 = 3'b001,
      MODE_FS60_R2 = 3'b010,
      MODE_LS_R1   = 3'b011,
      MODE_LS_R2   = 3'b100
   } phy_mode_t;

   // low swing ignores the de-emphasis bit; -6 dB exists only at rate 2
   function automatic phy_mode_t mode_of(input logic gen2, input logic low,
                                         input logic d6);
      if (low) begin
         return gen2 ? MODE_LS_R2 : MODE_LS_R1;
      end else if (gen2) begin
         return d6 ? MODE_FS60_R2 : MODE_FS35_R2;
      end
      return MODE_FS35_R1;
   endfunction : mode_of

   function automatic logic is_rate2(input phy_mode_t m);
      return (m == MODE_FS35_R2) || (m == MODE_FS60_R2) || (m == MODE_LS_R2);
   endfunction : is_rate2
endpackage : serdes_tx_pkg

// ==== hw/lane_setting_if.sv ====
// per-lane bundle between the register bank and the lane selector
`timescale 1ns/100ps
interface lane_setting_if;
   import serdes_tx_pkg::*;
   phy_mode_t                 mode;
   logic [TM_W-1:0]           margin;
   logic [FIRST_W-1:0]        first;
   logic [SECOND_W-1:0]       second;
   logic [DVL_W-1:0]          drive;
   logic [DC_W-1:0]           fdc;
   logic [DC_W-1:0]           cdc;
   logic [EQ_W-1:0]           eq;
   logic [SLEW_W-1:0]         cslew;
   logic [SLEW_W-1:0]         fslew;
   logic                      margin_on;
   logic [TM_W-1:0]           margin_level;

   modport ctrl (output mode, margin, first, second,
                 input drive, fdc, cdc, eq, cslew, fslew, margin_on, margin_level);
   modport sel  (input mode, margin, first, second,
                 output drive, fdc, cdc, eq, cslew, fslew, margin_on, margin_level);
endinterface : lane_setting_if

// ==== hw/lane_tx_select.sv ====
// picks the field set of one lane for the current phy mode
`timescale 1ns/100ps
module lane_tx_select
   import serdes_tx_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // lane bundle
   lane_setting_if.sel     s
);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s.drive <= '0;
         s.fdc   <= '0;
         s.cdc   <= '0;
         s.eq    <= '0;
      end else begin
         case (s.mode)
            MODE_FS35_R1: begin
               s.drive <= s.second[F_DVL35R1+:DVL_W];
               s.fdc   <= s.second[F_FDC35R1+:DC_W];
               s.cdc   <= s.first[F_CDC35R1+:DC_W];
               s.eq    <= s.first[F_EQ35R1+:EQ_W];
            end
            MODE_FS35_R2: begin
               s.drive <= s.second[F_DVL35R2+:DVL_W];
               s.fdc   <= s.second[F_FDC35R2+:DC_W];
               s.cdc   <= s.first[F_CDC35R2+:DC_W];
               s.eq    <= s.first[F_EQ35R2+:EQ_W];
            end
            MODE_FS60_R2: begin
               s.drive <= s.second[F_DVL60R2+:DVL_W];
               s.fdc   <= s.second[F_FDC60R2+:DC_W];
               s.cdc   <= s.first[F_CDC60R2+:DC_W];
               s.eq    <= s.first[F_EQ60R2+:EQ_W];
            end
            MODE_LS_R1: begin
               s.drive <= s.second[F_DVLLSR1+:DVL_W];
               s.fdc   <= '0;
               s.cdc   <= '0;
               s.eq    <= '0;
            end
            MODE_LS_R2: begin
               s.drive <= s.second[F_DVLLSR2+:DVL_W];
               s.fdc   <= '0;
               s.cdc   <= '0;
               s.eq    <= '0;
            end
            default: begin
               s.drive <= s.second[F_DVL35R1+:DVL_W];
               s.fdc   <= s.second[F_FDC35R1+:DC_W];
               s.cdc   <= s.first[F_CDC35R1+:DC_W];
               s.eq    <= s.first[F_EQ35R1+:EQ_W];
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s.cslew <= '0;
         s.fslew <= '0;
      end else if (is_rate2(s.mode)) begin
         s.cslew <= s.first[F_CSLEW2+:SLEW_W];
         s.fslew <= s.first[F_FSLEW2+:SLEW_W];
      end else begin
         s.cslew <= s.first[F_CSLEW1+:SLEW_W];
         s.fslew <= s.first[F_FSLEW1+:SLEW_W];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s.margin_on    <= 1'b0;
         s.margin_level <= TM_NORMAL;
      end else begin
         s.margin_on    <= (s.margin != TM_NORMAL);
         s.margin_level <= s.margin;
      end
   end

   property p_margin;
      @(posedge clk) disable iff (!rst_n)
      (s.margin != TM_NORMAL) |=> (s.margin_on && s.margin_level == $past(s.margin));
   endproperty
   a_margin: assert property (p_margin) else $error("margin not applied");

   property p_ls_zero;
      @(posedge clk) disable iff (!rst_n)
      (s.mode == MODE_LS_R1 || s.mode == MODE_LS_R2) |=> (s.cdc == '0 && s.eq == '0);
   endproperty
   a_ls_zero: assert property (p_ls_zero) else $error("low swing kept emphasis");

   property p_g1_slew;
      @(posedge clk) disable iff (!rst_n)
      (s.mode == MODE_FS35_R1) |=> (s.cslew == $past(s.first[F_CSLEW1+:SLEW_W]));
   endproperty
   a_g1_slew: assert property (p_g1_slew) else $error("rate 1 slew wrong");

   property p_fs60;
      @(posedge clk) disable iff (!rst_n)
      (s.mode == MODE_FS60_R2) |=> (s.drive == $past(s.second[F_DVL60R2+:DVL_W]));
   endproperty
   a_fs60: assert property (p_fs60) else $error("6 dB drive wrong");
endmodule : lane_tx_select

// ==== hw/serdes_tx_setting_select.sv ====
// serdes transmit/receive setting bank for an even/odd port pair
`timescale 1ns/100ps
module serdes_tx_setting_select
   import serdes_tx_pkg::*;
(
   // clock and reset
   input  wire logic                               clk,
   input  wire logic                               rst_n,
   // write paths: cfg, smbus, eeprom
   input  wire logic [NSRC-1:0]                    wr_en,
   input  wire logic [NSRC-1:0][AW-1:0]            wr_addr,
   input  wire logic [NSRC-1:0][DW-1:0]            wr_data,
   output      logic [NSRC-1:0]                    wr_ack,
   // port state, index 0 even port
   input  wire logic [NQ-1:0]                      port_gen2,
   input  wire logic [NQ-1:0]                      port_low_swing,
   input  wire logic [NQ-1:0]                      port_deemph6,
   input  wire logic [NQ-1:0][TM_W-1:0]            tx_margin_select,
   input  wire logic                               merged_x8,
   // lane settings to the serdes
   output      logic [NLT-1:0][DVL_W-1:0]          drive_level,
   output      logic [NLT-1:0][DC_W-1:0]           fine_deemph,
   output      logic [NLT-1:0][DC_W-1:0]           coarse_deemph,
   output      logic [NLT-1:0][EQ_W-1:0]           tx_equalize,
   output      logic [NLT-1:0][SLEW_W-1:0]         coarse_slew,
   output      logic [NLT-1:0][SLEW_W-1:0]         fine_slew,
   output      logic [NLT-1:0]                     margin_override,
   output      logic [NLT-1:0][TM_W-1:0]           margin_level,
   output      logic [NLT-1:0][RXEQ_W-1:0]         rx_equalize,
   // status
   output      phy_mode_t [NQ-1:0]                 quad_mode
);

   logic [NSRC-1:0]                  wr_ack_reg;
   logic [NSRC-1:0]                  req;
   logic                             w_go;
   logic [SB-1:0]                    w_src;
   logic [AW-1:0]                    w_addr;
   logic [DW-1:0]                    w_data;
   logic [FIRST_W-1:0]               first_reg [NLT];
   logic [SECOND_W-1:0]              second_reg [NLT];
   logic [RXEQ_W-1:0]                rxeq_reg [NLT];
   logic [APPLY_W-1:0]               apply_reg [NQ];
   phy_mode_t                        quad_mode_reg [NQ];
   phy_mode_t                        qmode [NQ];
   logic [TM_W-1:0]                  qmargin [NQ];

   // decides whether a write hits lane li of a quad
   function automatic logic lane_on(input logic [APPLY_W-1:0] ap, input int li);
      return ap[F_ALL] || (ap[F_LANE+:LSB_W] == LSB_W'(li));
   endfunction : lane_on

   // a source just acknowledged is masked one cycle so a held request
   // is not written twice
   assign req = wr_en & ~wr_ack_reg;

   always_comb begin
      w_go  = 1'b0;
      w_src = '0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (req[i]) begin
            w_go  = 1'b1;
            w_src = SB'(i);
         end
      end
      w_addr = wr_addr[w_src];
      w_data = wr_data[w_src];
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ack_reg <= '0;
      end else if (w_go) begin
         wr_ack_reg <= NSRC'(1) << w_src;
      end else begin
         wr_ack_reg <= '0;
      end
   end

   assign wr_ack = wr_ack_reg;

   genvar q, l;
   generate
      for (q = 0; q < NQ; q++) begin : g_quad
         localparam int G = (q / 2) * 2;
         always_comb begin
            if (merged_x8) begin
               qmode[q]   = mode_of(port_gen2[G], port_low_swing[G], port_deemph6[G]);
               qmargin[q] = tx_margin_select[G];
            end else begin
               qmode[q]   = mode_of(port_gen2[q], port_low_swing[q], port_deemph6[q]);
               qmargin[q] = tx_margin_select[q];
            end
         end

         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               quad_mode_reg[q] <= MODE_FS35_R1;
            end else begin
               quad_mode_reg[q] <= qmode[q];
            end
         end

         assign quad_mode[q] = quad_mode_reg[q];

         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               apply_reg[q] <= APPLY_RST;
            end else if (w_go && w_addr == AW'(A_APPLY + q)) begin
               apply_reg[q] <= w_data[APPLY_W-1:0];
            end
         end
      end

      for (l = 0; l < NLT; l++) begin : g_lane
         localparam int Q  = l / NL;
         localparam int LI = l % NL;
         lane_setting_if s_if ();

         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               first_reg[l] <= FIRST_RST;
            end else if (w_go && w_addr == AW'(A_FIRST + Q) && lane_on(apply_reg[Q], LI)) begin
               first_reg[l] <= w_data[FIRST_W-1:0];
            end
         end

         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               second_reg[l] <= SECOND_RST;
            end else if (w_go && w_addr == AW'(A_SECOND + Q) && lane_on(apply_reg[Q], LI)) begin
               second_reg[l] <= w_data[SECOND_W-1:0];
            end
         end

         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               rxeq_reg[l] <= RXEQ_RST;
            end else if (w_go && w_addr == AW'(A_RXEQ + l)) begin
               rxeq_reg[l] <= w_data[RXEQ_W-1:0];
            end
         end

         assign rx_equalize[l] = rxeq_reg[l];

         assign s_if.mode   = qmode[Q];
         assign s_if.margin = qmargin[Q];
         assign s_if.first  = first_reg[l];
         assign s_if.second = second_reg[l];

         lane_tx_select u_sel (
            .clk   (clk),
            .rst_n (rst_n),
            .s     (s_if.sel)
         );

         assign drive_level[l]     = s_if.drive;
         assign fine_deemph[l]     = s_if.fdc;
         assign coarse_deemph[l]   = s_if.cdc;
         assign tx_equalize[l]     = s_if.eq;
         assign coarse_slew[l]     = s_if.cslew;
         assign fine_slew[l]       = s_if.fslew;
         assign margin_override[l] = s_if.margin_on;
         assign margin_level[l]    = s_if.margin_level;
      end
   endgenerate

   property p_cfg_first;
      @(posedge clk) disable iff (!rst_n)
      (req[SRC_CFG] && req[SRC_SMB]) |=> (wr_ack_reg[SRC_CFG] && !wr_ack_reg[SRC_SMB]);
   endproperty
   a_cfg_first: assert property (p_cfg_first) else $error("config path lost priority");

   property p_ee_taken;
      @(posedge clk) disable iff (!rst_n)
      (req == NSRC'(1 << SRC_EE)) |=> (wr_ack_reg[SRC_EE] ##1 !wr_ack_reg[SRC_EE]);
   endproperty
   a_ee_taken: assert property (p_ee_taken) else $error("eeprom write not acked once");

   property p_rxeq_wr;
      @(posedge clk) disable iff (!rst_n)
      (w_go && w_addr == A_RXEQ) |=> (rxeq_reg[0] == $past(w_data[RXEQ_W-1:0]));
   endproperty
   a_rxeq_wr: assert property (p_rxeq_wr) else $error("rx equalizer not written");

   property p_all_lanes;
      @(posedge clk) disable iff (!rst_n)
      (w_go && w_addr == A_FIRST && apply_reg[0][F_ALL])
         |=> (first_reg[NL-1] == $past(w_data[FIRST_W-1:0]));
   endproperty
   a_all_lanes: assert property (p_all_lanes) else $error("all-lane write missed");

   property p_one_lane;
      @(posedge clk) disable iff (!rst_n)
      (w_go && w_addr == A_FIRST && !apply_reg[0][F_ALL] && apply_reg[0][F_LANE+:LSB_W] != '0)
         |=> $stable(first_reg[0]);
   endproperty
   a_one_lane: assert property (p_one_lane) else $error("unselected lane written");

   property p_odd_quad;
      @(posedge clk) disable iff (!rst_n)
      (w_go && w_addr == A_FIRST + 8'h01) |=> $stable(first_reg[0]);
   endproperty
   a_odd_quad: assert property (p_odd_quad) else $error("quad 1 write hit quad 0");

   property p_merged;
      @(posedge clk) disable iff (!rst_n)
      merged_x8 |=> (quad_mode_reg[1] == quad_mode_reg[0]);
   endproperty
   a_merged: assert property (p_merged) else $error("merged quads disagree");

   property p_ls_mode;
      @(posedge clk) disable iff (!rst_n)
      port_low_swing[0] |=> (quad_mode_reg[0] == MODE_LS_R1 || quad_mode_reg[0] == MODE_LS_R2);
   endproperty
   a_ls_mode: assert property (p_ls_mode) else $error("low swing not forced");

   property p_ack_onehot;
      @(posedge clk) disable iff (!rst_n)
      $onehot0(wr_ack_reg);
   endproperty
   a_ack_onehot: assert property (p_ack_onehot) else $error("two sources acked");

   property p_cfg_taken;
      @(posedge clk) disable iff (!rst_n)
      req[SRC_CFG] |=> wr_ack_reg[SRC_CFG];
   endproperty
   a_cfg_taken: assert property (p_cfg_taken) else $error("config write not taken");

   property p_smb_first;
      @(posedge clk) disable iff (!rst_n)
      (!req[SRC_CFG] && req[SRC_SMB] && req[SRC_EE]) |=> wr_ack_reg[SRC_SMB];
   endproperty
   a_smb_first: assert property (p_smb_first) else $error("smbus lost to eeprom");

   property p_apply_wr;
      @(posedge clk) disable iff (!rst_n)
      (w_go && w_addr == A_APPLY) |=> (apply_reg[0] == $past(w_data[APPLY_W-1:0]));
   endproperty
   a_apply_wr: assert property (p_apply_wr) else $error("lane select not written");

   property p_second_lane;
      @(posedge clk) disable iff (!rst_n)
      (w_go && w_addr == A_SECOND + 8'h01 && apply_reg[1] == 3'h2)
         |=> (second_reg[NL+2] == $past(w_data[SECOND_W-1:0]));
   endproperty
   a_second_lane: assert property (p_second_lane) else $error("chosen lane missed");

   property p_rate2_sel;
      @(posedge clk) disable iff (!rst_n)
      (port_gen2[0] && !port_low_swing[0] && !port_deemph6[0])
         |=> (quad_mode_reg[0] == MODE_FS35_R2);
   endproperty
   a_rate2_sel: assert property (p_rate2_sel) else $error("rate 2 set not applied");

   property p_own_quad;
      @(posedge clk) disable iff (!rst_n)
      (!merged_x8 && port_gen2[1] && port_deemph6[1] && !port_low_swing[1])
         |=> (quad_mode_reg[1] == MODE_FS60_R2);
   endproperty
   a_own_quad: assert property (p_own_quad) else $error("x4 quad not own");

   property p_rxeq_lone;
      @(posedge clk) disable iff (!rst_n)
      (w_go && w_addr != A_RXEQ + 8'h07) |=> $stable(rxeq_reg[NLT-1]);
   endproperty
   a_rxeq_lone: assert property (p_rxeq_lone) else $error("lane 7 rx eq disturbed");

   c_rate_change: cover property (@(posedge clk) disable iff (!rst_n)
      quad_mode_reg[0] == MODE_FS35_R1 ##1 quad_mode_reg[0] == MODE_FS35_R2);
   c_all_src: cover property (@(posedge clk) disable iff (!rst_n) &wr_en);
   c_merged_ls: cover property (@(posedge clk) disable iff (!rst_n)
      merged_x8 && port_low_swing[0] && !port_low_swing[1]);
   c_one_lane: cover property (@(posedge clk) disable iff (!rst_n)
      w_go && w_addr == A_FIRST && !apply_reg[0][F_ALL]);
   c_own_fs60: cover property (@(posedge clk) disable iff (!rst_n)
      !merged_x8 && quad_mode_reg[1] == MODE_FS60_R2);
endmodule : serdes_tx_setting_select

// ==== sim/serdes_tx_setting_select_tb.sv ====
// self-checking bench for the serdes transmit setting bank
`timescale 1ns/100ps
module serdes_tx_setting_select_tb;
   import serdes_tx_pkg::*;

   typedef struct packed {
      logic [DVL_W-1:0]  drv;
      logic [DC_W-1:0]   fdc;
      logic [DC_W-1:0]   cdc;
      logic [EQ_W-1:0]   eq;
      logic [SLEW_W-1:0] cs;
      logic [SLEW_W-1:0] fs;
   } lane_fields_t;
   typedef struct packed {
      logic      g;
      logic      l;
      logic      d;
      phy_mode_t m;
   } mode_row_t;

   // port state per row and the mode it should select
   localparam mode_row_t ROWS [7] = '{
      '{1'h0, 1'h0, 1'h0, MODE_FS35_R1}, '{1'h1, 1'h0, 1'h0, MODE_FS35_R2},
      '{1'h1, 1'h0, 1'h1, MODE_FS60_R2}, '{1'h0, 1'h1, 1'h0, MODE_LS_R1},
      '{1'h1, 1'h1, 1'h0, MODE_LS_R2},   '{1'h0, 1'h0, 1'h1, MODE_FS35_R1},
      '{1'h1, 1'h1, 1'h1, MODE_LS_R2}};

   logic                          clk              = 1'h0;
   logic                          rst_n            = 1'h0;
   logic [NSRC-1:0]               wr_en            = '0;
   logic [NSRC-1:0][AW-1:0]       wr_addr          = '0;
   logic [NSRC-1:0][DW-1:0]       wr_data          = '0;
   logic [NQ-1:0]                 port_gen2        = '0;
   logic [NQ-1:0]                 port_low_swing   = '0;
   logic [NQ-1:0]                 port_deemph6     = '0;
   logic [NQ-1:0][TM_W-1:0]       tx_margin_select = '0;
   logic                          merged_x8        = 1'h0;
   logic [NSRC-1:0]               wr_ack;
   logic [NLT-1:0][DVL_W-1:0]     drive_level;
   logic [NLT-1:0][DC_W-1:0]      fine_deemph;
   logic [NLT-1:0][DC_W-1:0]      coarse_deemph;
   logic [NLT-1:0][EQ_W-1:0]      tx_equalize;
   logic [NLT-1:0][SLEW_W-1:0]    coarse_slew;
   logic [NLT-1:0][SLEW_W-1:0]    fine_slew;
   logic [NLT-1:0]                margin_override;
   logic [NLT-1:0][TM_W-1:0]      margin_level;
   logic [NLT-1:0][RXEQ_W-1:0]    rx_equalize;
   phy_mode_t [NQ-1:0]            quad_mode;
   // bench copy of the register contents
   logic [FIRST_W-1:0]            mf [NLT];
   logic [SECOND_W-1:0]           ms [NLT];
   logic [RXEQ_W-1:0]             mrx [NLT];
   logic [APPLY_W-1:0]            ma [NQ];
   int                            n_fail    = 0;
   int                            tests_run = 0;

   always #4 clk = ~clk;

   serdes_tx_setting_select DUT (
      .clk(clk), .rst_n(rst_n), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
      .wr_ack(wr_ack), .port_gen2(port_gen2), .port_low_swing(port_low_swing),
      .port_deemph6(port_deemph6), .tx_margin_select(tx_margin_select),
      .merged_x8(merged_x8), .drive_level(drive_level), .fine_deemph(fine_deemph),
      .coarse_deemph(coarse_deemph), .tx_equalize(tx_equalize), .coarse_slew(coarse_slew),
      .fine_slew(fine_slew), .margin_override(margin_override),
      .margin_level(margin_level), .rx_equalize(rx_equalize), .quad_mode(quad_mode));

   task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk

   // low swing carries drive and slew only, slew follows the rate
   function automatic lane_fields_t pick(logic [FIRST_W-1:0] f, logic [SECOND_W-1:0] s,
                                         phy_mode_t m);
      lane_fields_t e;
      logic         r2;
      e = '0;
      r2 = (m == MODE_FS35_R2) || (m == MODE_FS60_R2) || (m == MODE_LS_R2);
      e.cs = r2 ? f[F_CSLEW2+:SLEW_W] : f[F_CSLEW1+:SLEW_W];
      e.fs = r2 ? f[F_FSLEW2+:SLEW_W] : f[F_FSLEW1+:SLEW_W];
      case (m)
         MODE_FS35_R1: begin
            e.drv = s[F_DVL35R1+:DVL_W];
            e.fdc = s[F_FDC35R1+:DC_W];
            e.cdc = f[F_CDC35R1+:DC_W];
            e.eq  = f[F_EQ35R1+:EQ_W];
         end
         MODE_FS35_R2: begin
            e.drv = s[F_DVL35R2+:DVL_W];
            e.fdc = s[F_FDC35R2+:DC_W];
            e.cdc = f[F_CDC35R2+:DC_W];
            e.eq  = f[F_EQ35R2+:EQ_W];
         end
         MODE_FS60_R2: begin
            e.drv = s[F_DVL60R2+:DVL_W];
            e.fdc = s[F_FDC60R2+:DC_W];
            e.cdc = f[F_CDC60R2+:DC_W];
            e.eq  = f[F_EQ60R2+:EQ_W];
         end
         MODE_LS_R1: e.drv = s[F_DVLLSR1+:DVL_W];
         default:    e.drv = s[F_DVLLSR2+:DVL_W];
      endcase
      return e;
   endfunction : pick

   task automatic check_all();
      phy_mode_t       m;
      lane_fields_t    got;
      logic [TM_W-1:0] gov;
      int              q;
      int              p;
      for (int l = 0; l < NLT; l++) begin
         q = l / NL;
         // a merged pair follows the even port
         p = merged_x8 ? 0 : q;
         m = port_gen2[p] ? (port_deemph6[p] ? MODE_FS60_R2 : MODE_FS35_R2) : MODE_FS35_R1;
         if (port_low_swing[p]) begin
            m = port_gen2[p] ? MODE_LS_R2 : MODE_LS_R1;
         end
         gov = tx_margin_select[p];
         got = {drive_level[l], fine_deemph[l], coarse_deemph[l], tx_equalize[l],
                coarse_slew[l], fine_slew[l]};
         chk($sformatf("lane %0d fields", l), pick(mf[l], ms[l], m), got);
         chk($sformatf("quad %0d mode", q), m, quad_mode[q]);
         chk($sformatf("lane %0d margin flag", l), gov != TM_NORMAL, margin_override[l]);
         chk($sformatf("lane %0d margin level", l), gov, margin_level[l]);
         chk($sformatf("lane %0d rx eq", l), mrx[l], rx_equalize[l]);
      end
   endtask : check_all

   // holds the request until the ack edge; the bench copy follows the lane select
   task automatic wr(int src, logic [AW-1:0] a, logic [DW-1:0] d, int exp_wait);
      int waited;
      int q;
      waited = 0;
      q = a[1:0];
      @(posedge clk);
      wr_en[src]   <= 1'h1;
      wr_addr[src] <= a;
      wr_data[src] <= d;
      do begin
         @(posedge clk);
         waited++;
      end while (wr_ack[src] !== 1'h1 && waited < 20);
      wr_en[src] <= 1'h0;
      chk("write ack wait", exp_wait, waited);
      if (a >= A_RXEQ && a < A_RXEQ + NLT) begin
         mrx[a - A_RXEQ] = d[RXEQ_W-1:0];
      end
      if (a >= A_APPLY && a < A_APPLY + NQ) begin
         ma[a - A_APPLY] = d[APPLY_W-1:0];
      end
      for (int l = 0; l < NL; l++) begin
         if (q < NQ && (ma[q][2] || ma[q][1:0] == l) && a == A_FIRST + q) begin
            mf[q * NL + l] = d[FIRST_W-1:0];
         end
         if (q < NQ && (ma[q][2] || ma[q][1:0] == l) && a == A_SECOND + q) begin
            ms[q * NL + l] = d[SECOND_W-1:0];
         end
      end
   endtask : wr

   // inputs land on one edge, the registered outputs follow on the next
   task automatic set_ports(logic [1:0] g, logic [1:0] l, logic [1:0] d,
                            logic [TM_W-1:0] t0, logic [TM_W-1:0] t1, logic mx);
      @(posedge clk);
      port_gen2        <= g;
      port_low_swing   <= l;
      port_deemph6     <= d;
      tx_margin_select <= {t1, t0};
      merged_x8        <= mx;
      @(posedge clk);
      #1;
      check_all();
   endtask : set_ports

   task automatic do_reset();
      @(posedge clk);
      rst_n <= 1'h0;
      for (int l = 0; l < NLT; l++) begin
         mf[l]  = FIRST_RST;
         ms[l]  = SECOND_RST;
         mrx[l] = RXEQ_RST;
      end
      ma = '{APPLY_RST, APPLY_RST};
      repeat (5) @(posedge clk);
      #1;
      chk("reset ack", 0, wr_ack);
      chk("reset drive", 0, drive_level);
      chk("reset mode", 0, quad_mode);
      chk("reset margin", 0, margin_override);
      @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      #1;
      check_all();
      $display("reset test done");
   endtask : do_reset

   task automatic run_rows();
      for (int i = 0; i < 7; i++) begin
         set_ports({ROWS[(i + 1) % 7].g, ROWS[i].g}, {ROWS[(i + 1) % 7].l, ROWS[i].l},
                   {ROWS[(i + 1) % 7].d, ROWS[i].d}, 3'h0, 3'h0, 1'h0);
         chk("row mode", ROWS[i].m, quad_mode[0]);
      end
      $display("mode table test done");
   endtask : run_rows

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : complete_run

   initial begin
      repeat (5000) @(posedge clk);
      n_fail++;
      complete_run();
   end

   initial begin
      do_reset();
      run_rows();
      set_ports(2'h0, 2'h0, 2'h0, 3'h0, 3'h0, 1'h0);
      wr(SRC_CFG, A_APPLY + 8'h01, 34'h000000002, 2);
      wr(SRC_SMB, A_FIRST + 8'h01, 34'h0005A5A5A, 2);
      wr(SRC_EE, A_SECOND + 8'h01, 34'h2ABCDE123, 2);
      #1;
      check_all();
      wr(SRC_CFG, A_FIRST, 34'h000654321, 2);
      #1;
      check_all();
      wr(SRC_SMB, A_APPLY, 34'h000000001, 2);
      wr(SRC_EE, A_FIRST, 34'h000123456, 2);
      #1;
      check_all();
      run_rows();
      for (int l = 0; l < NLT; l++) begin
         wr(l % NSRC, A_RXEQ + l[AW-1:0], 34'(l + 9), 2);
      end
      wr(SRC_SMB, 8'hFF, '1, 2);
      wr(SRC_CFG, A_FIRST + 8'h02, '1, 2);
      #1;
      check_all();
      $display("write path test done");
      fork
         wr(SRC_CFG, A_RXEQ, 34'h000000003, 2);
         wr(SRC_SMB, A_RXEQ + 8'h01, 34'h000000004, 3);
         wr(SRC_EE, A_RXEQ + 8'h02, 34'h000000005, 4);
      join
      #1;
      check_all();
      $display("priority test done");
      // margin governs one or both quads
      set_ports(2'h0, 2'h0, 2'h0, 3'h3, 3'h0, 1'h0);
      set_ports(2'h0, 2'h0, 2'h0, 3'h3, 3'h0, 1'h1);
      set_ports(2'h0, 2'h0, 2'h0, 3'h0, 3'h5, 1'h1);
      set_ports(2'h3, 2'h0, 2'h0, 3'h0, 3'h5, 1'h0);
      set_ports(2'h0, 2'h0, 2'h0, 3'h7, 3'h7, 1'h0);
      set_ports(2'h1, 2'h1, 2'h2, 3'h0, 3'h0, 1'h1);
      $display("margin test done");
      do_reset();
      complete_run();
   end
endmodule : serdes_tx_setting_select_tb
